// file: hw/calendar_clock_register_bank.sv
// APB register bank and calendar counting chain of the real-time clock
`timescale 1ns/1ps
`include "rtc_consts.svh"

// Contract
// - Sixteen byte registers at indexes 0x0 to 0xF with listed offsets.
// - Clock and alarm banks share addresses; bank-select bit routes each access.
// - Indexes 0x3, 0x9-0xB, 0xE, 0xF read zero and ignore writes.
// - Reset clears only bank, second_bit_a, interrupt enable and reset-control bits.
// - Time, date, year, leap and hour mode survive system reset.
// - Clock-bank seconds are BCD in bits 6:0, bit 7 reads zero.
// - Minutes are BCD in bits 6:0 in both banks.
// - Hours use bits 5:0; bit 5 is twenty-hours or afternoon flag.
// - Weekday in bits 2:0, BCD date in bits 5:0, both banks.
// - Index 0x6: month in clock bank, hour-mode bit 0 in alarm bank.
// - Index 0x7 of clock bank holds two BCD year digits.
// - Index 0x7 of alarm bank holds two-bit leap-year setting.
// - Bank-select register bits 7,4,3,2,0, identical in both banks.
// - Reset-control bits 7..4; software writes ones to low bits.
// - Clock-bank time reads capture live counter state at the read.
// - Alarm-bank reads capture current register state.
// - Alarm-bank seconds slot has no function.
// - Hour-mode one selects 24-hour, zero selects 12-hour with afternoon.
// - Year wraps 99 to 00; every fourth year is a leap year.
module calendar_clock_register_bank #(
  parameter int CYCLES_PER_16HZ = `CYCLES_PER_16HZ
) (
  input  wire logic        pclk,           // APB clock, 40 MHz
  input  wire logic        presetn,        // Asynchronous reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction, high for write
  input  wire logic [5:0]  paddr,          // APB byte address within the block
  input  wire logic [31:0] pwdata,         // APB write data
  input  wire logic [3:0]  pstrb,          // APB byte strobes
  output logic             pready,         // APB ready
  output logic [31:0]      prdata,         // APB read data
  output logic             pslverr,        // APB error
  output logic             one_hz_out,     // 1 Hz square wave when enabled
  output logic             sixteen_hz_out, // 16 Hz square wave when enabled
  output logic             alarm_out       // One-cycle pulse on an alarm match
);

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  function automatic rtc_pkg::bcd_byte_t bcd_inc(input rtc_pkg::bcd_byte_t v);
    rtc_pkg::bcd_byte_t r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    return r;
  endfunction : bcd_inc

  function automatic rtc_pkg::bcd_byte_t last_date(input rtc_pkg::bcd_byte_t m,
                                                    input logic leap);
    rtc_pkg::bcd_byte_t r;
    unique case (m)
      8'h02:                      r = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default:                    r = 8'h31;
    endcase
    return r;
  endfunction : last_date

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [3:0] index;
  logic       access;
  logic       bad_addr;
  logic       rd_capture;
  logic       wr_en;
  logic [7:0] wbyte;

  assign index      = paddr[5:2];
  assign access     = psel & penable;
  assign bad_addr   = (index == `IDX_RESERVED) | (paddr[1:0] != 2'b00);
  assign rd_capture = access & ~pready;
  // Write lands on the completing edge only, and never on an error
  assign wr_en      = access & pready & pwrite & ~pslverr & pstrb[0];
  assign wbyte      = pwdata[7:0];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  rtc_pkg::bcd_byte_t seconds, minutes, hours, weekday, date, month, year;
  rtc_pkg::bcd_byte_t alm_minutes, alm_hours, alm_weekday, alm_date;
  logic       hour_mode_select;
  logic [1:0] leap_setting;
  logic       bank;
  logic       second_bit_a;
  logic       interrupt_enable_bit;
  logic       clock_enable;
  logic       alarm_enable;
  logic       one_hz_enable;
  logic       sixteen_hz_enable;
  logic       clock_reset_bit;
  logic       alarm_reset_bit;

  // Write strobes per bank; the bank bit steers shared slots
  logic clk_wr;
  logic alm_wr;
  assign clk_wr = wr_en & ~bank;
  assign alm_wr = wr_en & bank;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic       tick16;
  logic       tick1;
  logic [3:0] phase;
  logic       half16;

  rtc_prescaler #(
    .CYCLES_PER_16HZ (CYCLES_PER_16HZ)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (clock_reset_bit),
    .tick16  (tick16),
    .tick1   (tick1),
    .phase   (phase),
    .half16  (half16)
  );

  // ----------------------------------------------------------------
  // Counting chain
  // ----------------------------------------------------------------
  rtc_pkg::bcd_byte_t next_seconds, next_minutes, next_hours, next_weekday;
  rtc_pkg::bcd_byte_t next_date, next_month, next_year;
  logic [1:0] next_leap;
  logic       carry_min, carry_hour, carry_day, carry_month, carry_year;
  logic       advance;

  assign advance = tick1 & clock_enable;

  // One second step; adjustment rounds to the nearest minute instead
  always_comb begin
    next_seconds = seconds;
    next_minutes = minutes;
    next_hours   = hours;
    next_weekday = weekday;
    next_date    = date;
    next_month   = month;
    next_year    = year;
    next_leap    = leap_setting;
    carry_min    = 1'b0;
    carry_hour   = 1'b0;
    carry_day    = 1'b0;
    carry_month  = 1'b0;
    carry_year   = 1'b0;
    if (advance) begin
      if (second_bit_a) begin
        next_seconds = 8'h00;
        carry_min    = (seconds >= `BCD_SECOND_BIT_A_UP);
      end else begin
        carry_min    = (seconds == `BCD_LAST_SECOND);
        next_seconds = carry_min ? 8'h00 : bcd_inc(seconds);
      end
    end
    if (carry_min) begin
      carry_hour   = (minutes == `BCD_LAST_SECOND);
      next_minutes = carry_hour ? 8'h00 : bcd_inc(minutes);
    end
    if (carry_hour) begin
      if (hour_mode_select) begin
        // 24-hour counting, bit 5 is the twenty-hours digit
        carry_day  = (hours == `BCD_LAST_HOUR_24);
        next_hours = carry_day ? 8'h00 : bcd_inc(hours);
      end else if ({3'b000, hours[4:0]} == `BCD_LAST_HOUR_12) begin
        // 11 o'clock rolls to 0 with the afternoon flag flipped
        carry_day  = hours[5];
        next_hours = {2'b00, ~hours[5], 5'h00};
      end else begin
        next_hours = {2'b00, hours[5], 5'(bcd_inc({3'b000, hours[4:0]}))};
      end
    end
    if (carry_day) begin
      next_weekday = (weekday == `LAST_WEEKDAY) ? 8'h00 : weekday + 8'h01;
      carry_month  = (date == last_date(month, leap_setting == 2'b00));
      next_date    = carry_month ? 8'h01 : bcd_inc(date);
    end
    if (carry_month) begin
      carry_year = (month == `BCD_LAST_MONTH);
      next_month = carry_year ? 8'h01 : bcd_inc(month);
    end
    if (carry_year) begin
      next_year = (year == `BCD_LAST_YEAR) ? 8'h00 : bcd_inc(year);
      next_leap = leap_setting + 2'b01;
    end
  end

  // ----------------------------------------------------------------
  // Clock bank counters, kept through reset
  // ----------------------------------------------------------------
  // No reset branch: the calendar must survive a system reset
  always_ff @(posedge pclk) begin
    seconds <= (clk_wr && index == `IDX_SECONDS) ? (wbyte & `MASK_SECONDS)
                                                 : next_seconds;
    minutes <= (clk_wr && index == `IDX_MINUTES) ? (wbyte & `MASK_MINUTES)
                                                 : next_minutes;
    hours   <= (clk_wr && index == `IDX_HOURS)   ? (wbyte & `MASK_HOURS)
                                                 : next_hours;
    weekday <= (clk_wr && index == `IDX_WEEKDAY) ? (wbyte & `MASK_WEEKDAY)
                                                 : next_weekday;
    date    <= (clk_wr && index == `IDX_DATE)    ? (wbyte & `MASK_DATE)
                                                 : next_date;
    month   <= (clk_wr && index == `IDX_MONTH_MODE) ? (wbyte & `MASK_MONTH)
                                                    : next_month;
    year    <= (clk_wr && index == `IDX_YEAR_LEAP)  ? (wbyte & `MASK_YEAR)
                                                    : next_year;
  end

  // ----------------------------------------------------------------
  // Alarm bank, kept through reset, cleared by alarm reset except hour mode and leap setting
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (alarm_reset_bit) begin
      alm_minutes <= 8'h00;
      alm_hours   <= 8'h00;
      alm_weekday <= 8'h00;
      alm_date    <= 8'h00;
    end else if (alm_wr) begin
      // Alarm seconds slot is not stored at all
      if (index == `IDX_MINUTES) alm_minutes <= wbyte & `MASK_MINUTES;
      if (index == `IDX_HOURS)   alm_hours   <= wbyte & `MASK_HOURS;
      if (index == `IDX_WEEKDAY) alm_weekday <= wbyte & `MASK_WEEKDAY;
      if (index == `IDX_DATE)    alm_date    <= wbyte & `MASK_DATE;
    end
  end

  // Hour mode and leap setting; leap setting steps with the year
  always_ff @(posedge pclk) begin
    if (alm_wr && index == `IDX_MONTH_MODE) begin
      hour_mode_select <= wbyte[0];
    end
    if (alm_wr && index == `IDX_YEAR_LEAP) begin
      leap_setting <= wbyte[1:0];
    end else begin
      leap_setting <= next_leap;
    end
  end

  // ----------------------------------------------------------------
  // Bank-select register
  // ----------------------------------------------------------------
  // Bank, second_bit_a and interrupt enable come out of reset cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank                 <= `RESET_BIT;
      second_bit_a         <= `RESET_BIT;
      interrupt_enable_bit <= `RESET_BIT;
    end else if (wr_en && index == `IDX_BANK_SELECT) begin
      bank                 <= wbyte[`BIT_BANK];
      second_bit_a         <= wbyte[`BIT_SECOND_BIT_A];
      interrupt_enable_bit <= wbyte[`BIT_INT_ENABLE];
    end else if (advance) begin
      second_bit_a <= 1'b0; // Adjustment done at the next second
    end
  end

  // Clock and alarm enables are left alone by reset
  always_ff @(posedge pclk) begin
    if (wr_en && index == `IDX_BANK_SELECT) begin
      clock_enable <= wbyte[`BIT_CLOCK_ENABLE];
      alarm_enable <= wbyte[`BIT_ALARM_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Reset-control register
  // ----------------------------------------------------------------
  // Clock and alarm resets are one-cycle actions that clear themselves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_hz_enable     <= `RESET_BIT;
      sixteen_hz_enable <= `RESET_BIT;
      clock_reset_bit   <= `RESET_BIT;
      alarm_reset_bit   <= `RESET_BIT;
    end else if (wr_en && index == `IDX_RESET_CTRL) begin
      one_hz_enable     <= wbyte[`BIT_ONE_HZ_EN];
      sixteen_hz_enable <= wbyte[`BIT_SIXTEEN_HZ_EN];
      clock_reset_bit   <= wbyte[`BIT_CLOCK_RESET];
      alarm_reset_bit   <= wbyte[`BIT_ALARM_RESET];
    end else begin
      clock_reset_bit   <= 1'b0;
      alarm_reset_bit   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [7:0] page_byte;
  logic [7:0] rst_byte;
  logic [7:0] rd_byte;

  assign page_byte = {interrupt_enable_bit, 2'b00, second_bit_a,
                      clock_enable, alarm_enable, 1'b0, bank};
  // Low bits are write-only ones and read back as zero
  assign rst_byte  = {one_hz_enable, sixteen_hz_enable,
                      clock_reset_bit, alarm_reset_bit, 4'h0};

  // Live counter values are sampled at the read, never a stale copy
  always_comb begin
    rd_byte = 8'h00;
    unique case (index)
      `IDX_SECONDS:     rd_byte = bank ? 8'h00 : seconds;
      `IDX_MINUTES:     rd_byte = bank ? alm_minutes : minutes;
      `IDX_HOURS:       rd_byte = bank ? alm_hours : hours;
      `IDX_WEEKDAY:     rd_byte = bank ? alm_weekday : weekday;
      `IDX_DATE:        rd_byte = bank ? alm_date : date;
      `IDX_MONTH_MODE:  rd_byte = bank ? {7'h00, hour_mode_select} : month;
      `IDX_YEAR_LEAP:   rd_byte = bank ? {6'h00, leap_setting} : year;
      `IDX_BANK_SELECT: rd_byte = page_byte;
      `IDX_RESET_CTRL:  rd_byte = rst_byte;
      default:          rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, outputs straight from flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_capture;
      pslverr <= rd_capture & bad_addr;
      if (rd_capture) begin
        prdata <= (pwrite || bad_addr) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm and frequency outputs
  // ----------------------------------------------------------------
  logic alarm_hit;

  // Alarms compare minutes, hours, weekday and date at each minute start
  assign alarm_hit = carry_min && (next_minutes == alm_minutes) &&
                     (next_hours == alm_hours) && (next_weekday == alm_weekday) &&
                     (next_date == alm_date);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_out      <= 1'b0;
      one_hz_out     <= 1'b0;
      sixteen_hz_out <= 1'b0;
    end else begin
      alarm_out      <= alarm_hit & alarm_enable & interrupt_enable_bit;
      one_hz_out     <= one_hz_enable & ~phase[3];
      sixteen_hz_out <= sixteen_hz_enable & half16;
    end
  end

  // Sixteenth tick is not used at all; the square wave comes from half16
  logic unused_tick16;
  assign unused_tick16 = tick16;

endmodule : calendar_clock_register_bank

// file: hw/rtc_consts.svh
// Offsets, field positions, reset values and timing counts of the calendar clock
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address on APB is four times the index)
// ----------------------------------------------------------------
`define IDX_SECONDS        4'h0
`define IDX_MINUTES        4'h1
`define IDX_HOURS          4'h2
`define IDX_UNUSED_3       4'h3
`define IDX_WEEKDAY        4'h4
`define IDX_DATE           4'h5
`define IDX_MONTH_MODE     4'h6
`define IDX_YEAR_LEAP      4'h7
`define IDX_BANK_SELECT    4'h8
`define IDX_RESET_CTRL     4'hc
`define IDX_RESERVED       4'hd

// ----------------------------------------------------------------
// Field masks of writable bits
// ----------------------------------------------------------------
`define MASK_SECONDS       8'h7f
`define MASK_MINUTES       8'h7f
`define MASK_HOURS         8'h3f
`define MASK_WEEKDAY       8'h07
`define MASK_DATE          8'h3f
`define MASK_MONTH         8'h1f
`define MASK_YEAR          8'hff
`define MASK_HOUR_MODE     8'h01
`define MASK_LEAP          8'h03

// ----------------------------------------------------------------
// Bank-select and reset-control bit positions
// ----------------------------------------------------------------
`define BIT_INT_ENABLE     7
`define BIT_SECOND_BIT_A         4
`define BIT_CLOCK_ENABLE   3
`define BIT_ALARM_ENABLE   2
`define BIT_BANK           0
`define BIT_ONE_HZ_EN      7
`define BIT_SIXTEEN_HZ_EN  6
`define BIT_CLOCK_RESET    5
`define BIT_ALARM_RESET    4

// ----------------------------------------------------------------
// Reset values and calendar limits (BCD)
// ----------------------------------------------------------------
`define RESET_BIT          1'b0
`define BCD_LAST_SECOND    8'h59
`define BCD_SECOND_BIT_A_UP      8'h30
`define BCD_LAST_HOUR_24   8'h23
`define BCD_LAST_HOUR_12   8'h11
`define BCD_LAST_MONTH     8'h12
`define BCD_LAST_YEAR      8'h99
`define LAST_WEEKDAY       8'h06

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCLK_PERIOD_NS     25
`define SIXTEEN_HZ_PERIOD_NS 62500000
`define CYCLES_PER_16HZ    (`SIXTEEN_HZ_PERIOD_NS / `PCLK_PERIOD_NS)

`endif

// file: hw/rtc_pkg.sv
// Types shared by the calendar clock register bank
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register index, one per byte register slot except the unused 0x3, 0x9-0xB, 0xE, 0xF
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    REG_SECONDS     = 4'h0,
    REG_MINUTES     = 4'h1,
    REG_HOURS       = 4'h2,
    REG_WEEKDAY     = 4'h4,
    REG_DATE        = 4'h5,
    REG_MONTH_MODE  = 4'h6,
    REG_YEAR_LEAP   = 4'h7,
    REG_BANK_SELECT = 4'h8,
    REG_RESET_CTRL  = 4'hc,
    REG_RESERVED    = 4'hd
  } reg_index_t;

  typedef logic [7:0] bcd_byte_t;

endpackage : rtc_pkg

// file: hw/rtc_prescaler.sv
// Divider from pclk down to sixteenth-second ticks and a 1 Hz tick
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_prescaler #(
  parameter int CYCLES_PER_16HZ = `CYCLES_PER_16HZ
) (
  input  wire logic       pclk,     // System clock
  input  wire logic       presetn,  // Asynchronous reset, active low
  input  wire logic       clear,    // Restart the divider from phase zero
  output logic            tick16,   // One-cycle pulse sixteen times a second
  output logic            tick1,    // One-cycle pulse once a second
  output logic [3:0]      phase,    // Sixteenths of the current second
  output logic            half16    // High in the first half of each 16 Hz period
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CYCLES_PER_16HZ < 4) begin : g_bad_count
    $error("rtc_prescaler: CYCLES_PER_16HZ must be at least 4");
  end

  localparam int CW = $clog2(CYCLES_PER_16HZ);
  localparam logic [CW-1:0] LAST = CW'(CYCLES_PER_16HZ - 1);
  localparam logic [CW-1:0] HALF = CW'(CYCLES_PER_16HZ / 2);

  logic [CW-1:0] count;

  // Cycle counter; a clear restarts the second so software sees a full one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= '0;
      phase  <= 4'h0;
      tick16 <= 1'b0;
      tick1  <= 1'b0;
    end else if (clear) begin
      count  <= '0;
      phase  <= 4'h0;
      tick16 <= 1'b0;
      tick1  <= 1'b0;
    end else begin
      tick16 <= (count == LAST);
      tick1  <= (count == LAST) && (phase == 4'hf);
      if (count == LAST) begin
        count <= '0;
        phase <= phase + 4'h1;
      end else begin
        count <= count + CW'(1);
      end
    end
  end

  // Square wave of the sixteenth-second rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half16 <= 1'b0;
    end else begin
      half16 <= (count < HALF);
    end
  end

endmodule : rtc_prescaler

// file: sim/calendar_clock_register_bank_tb.sv
// Self-checking bench for the calendar clock register bank
`timescale 1ns/1ps
module calendar_clock_register_bank_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        one_hz_out, sixteen_hz_out, alarm_out;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  logic        alarm_seen = 1'b0;

  calendar_clock_register_bank #(.CYCLES_PER_16HZ(8)) i_calendar_clock_register_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .one_hz_out(one_hz_out), .sixteen_hz_out(sixteen_hz_out),
    .alarm_out(alarm_out));

  // ------------------------------------------------------------
  // Clock and hang guard, a few hundred cycles are expected
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Alarm pulse lasts one cycle, so it is latched for the test to look at
  always @(posedge pclk) if (alarm_out === 1'b1) alarm_seen <= 1'b1;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d,
                      output logic [31:0] r);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, d};
    pstrb   <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps psel from being dropped and raised in one step
    @(posedge pclk);
  endtask : xfer

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask : wr

  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 8'h0, r);
    chk(r, e);
  endtask : rd

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // Clock counting is stopped first so stored fields cannot move under us
  task automatic t_fields;
    wr(4'h8, 8'h00);
    wr(4'h0, 8'hff); rd(4'h0, 32'h7f);
    wr(4'h1, 8'h59); rd(4'h1, 32'h59);
    wr(4'h2, 8'hff); rd(4'h2, 32'h3f);
    wr(4'h4, 8'hff); rd(4'h4, 32'h07);
    wr(4'h5, 8'hff); rd(4'h5, 32'h3f);
    wr(4'h6, 8'h12); rd(4'h6, 32'h12);
    wr(4'h7, 8'h99); rd(4'h7, 32'h99);
    $display("test fields done");
  endtask : t_fields

  // Alarm bank overlays the shared slots; clock bank values must survive
  task automatic t_banks;
    wr(4'h8, 8'h01); rd(4'h8, 32'h01);
    wr(4'h1, 8'h12); rd(4'h1, 32'h12);
    wr(4'h0, 8'h33); rd(4'h0, 32'h00);
    wr(4'h6, 8'hff); rd(4'h6, 32'h01);
    wr(4'h7, 8'hff); rd(4'h7, 32'h03);
    wr(4'h8, 8'h00); rd(4'h1, 32'h59);
    rd(4'h7, 32'h99);
    $display("test banks done");
  endtask : t_banks

  task automatic t_unused;
    logic [3:0] slots [6] = '{4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
    foreach (slots[k]) begin
      wr(slots[k], 8'hff);
      rd(slots[k], 32'h0);
    end
    $display("test unused done");
  endtask : t_unused

  // Control bits except the clock and alarm enables clear on reset while calendar contents are kept
  task automatic t_reset;
    wr(4'h8, 8'h91);
    wr(4'hc, 8'hcf);
    do_reset();
    rd(4'h8, 32'h00);
    rd(4'hc, 32'h00);
    rd(4'h7, 32'h99);
    rd(4'h1, 32'h59);
    $display("test reset done");
  endtask : t_reset

  // From 23:59:59 on 31-12-99 one tick rolls every field and hits the alarm;
  // minutes, month, year, 24-hour mode and leap 3 stand from earlier tests
  task automatic t_count;
    wr(4'hc, 8'h1f);
    wr(4'h8, 8'h01);
    wr(4'h5, 8'h01);
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h59);
    wr(4'h2, 8'h23);
    wr(4'h4, 8'h06);
    wr(4'h5, 8'h31);
    // Clock reset first, so no second can slip in before counting is enabled
    wr(4'hc, 8'hef);
    wr(4'h8, 8'h8c);
    repeat (16) @(posedge pclk);
    chk(one_hz_out, 1'b1);
    chk(sixteen_hz_out, 1'b1);
    repeat (70) @(posedge pclk);
    chk(one_hz_out, 1'b0);
    chk(sixteen_hz_out, 1'b0);
    chk(alarm_seen, 1'b0);
    repeat (50) @(posedge pclk);
    chk(alarm_seen, 1'b1);
    rd(4'h0, 32'h00);
    rd(4'h0, 32'h00);
    rd(4'h1, 32'h00);
    rd(4'h2, 32'h00);
    rd(4'h4, 32'h00);
    rd(4'h5, 32'h01);
    rd(4'h6, 32'h01);
    rd(4'h7, 32'h00);
    wr(4'h8, 8'h8d);
    rd(4'h7, 32'h00);
    $display("test count done");
  endtask : t_count

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 6'h0; pwdata = 32'h0;
    pstrb = 4'h0; presetn = 1'b0;
    do_reset();
    t_fields();
    t_banks();
    t_unused();
    t_reset();
    t_count();
    end_of_test();
  end
endmodule : calendar_clock_register_bank_tb

// file: sim/rtc_bank_checker_sva.sv
// Checker of APB timing and read fields of the calendar clock register bank
`timescale 1ns/1ps
module rtc_bank_checker #(
  parameter int CYCLES_PER_16HZ = 8
) (
  input wire logic        pclk,           // Clock
  input wire logic        presetn,        // Reset, active low
  input wire logic        psel,           // Select
  input wire logic        penable,        // Access phase
  input wire logic        pwrite,         // Direction
  input wire logic [5:0]  paddr,          // Address
  input wire logic [31:0] pwdata,         // Write data
  input wire logic [3:0]  pstrb,          // Strobes
  input wire logic        pready,         // Ready
  input wire logic [31:0] prdata,         // Read data
  input wire logic        pslverr,        // Error
  input wire logic        one_hz_out,     // 1 Hz output
  input wire logic        sixteen_hz_out, // 16 Hz output
  input wire logic        alarm_out       // Alarm pulse
);
  // ------------------------------------------------------------
  // First access edge and register index
  // ------------------------------------------------------------
  logic       acc;
  logic [3:0] idx;
  assign acc = psel && penable && !pready;
  assign idx = paddr[5:2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_one_wait; acc |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready stuck");
  property p_no_err; acc && idx != 4'hd && paddr[1:0] == 2'b00 |=> !pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("spurious error");
  property p_unused; acc && !pwrite && idx inside {4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf}
    |=> prdata == 32'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused slot not zero");
  property p_sec_top; acc && !pwrite && idx == 4'h0 |=> !prdata[7]; endproperty
  a_sec_top: assert property (p_sec_top) else $error("seconds bit 7 set");
  property p_hour_top; acc && !pwrite && idx == 4'h2 |=> prdata[7:6] == 2'b00; endproperty
  a_hour_top: assert property (p_hour_top) else $error("hours top bits set");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_quiet; $rose(presetn) |-> !one_hz_out && !sixteen_hz_out && !alarm_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule : rtc_bank_checker

bind calendar_clock_register_bank rtc_bank_checker #(.CYCLES_PER_16HZ(CYCLES_PER_16HZ)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .one_hz_out(one_hz_out), .sixteen_hz_out(sixteen_hz_out),
  .alarm_out(alarm_out));
